// file: hdl/symbol_codec_map.svh
`ifndef SYMBOL_CODEC_MAP_SVH
`define SYMBOL_CODEC_MAP_SVH

// Control code groups
`define CG_IDLE 5'h1F
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0D
`define CG_R 5'h07
`define CG_H 5'h04

// Nibbles presented to the MAC
`define NIB_SSD 4'h5
`define NIB_BAD_SSD 4'hE
`define NIB_ZERO 4'h0

// Last bit slot of a serialised code group
`define SYM_LAST_BIT 3'h4

// Low scrambler seed bits, keeps the seed non-zero for any address
`define SEED_LOW 6'h3F

// MLT-3 level zero; plus one (2'h1) and minus one (2'h3) are formed in the codec
`define LVL_ZERO 2'h0

// Transmit buffer shape: end flag, error flag, nibble
`define TXQ_WIDTH 6
`define TXQ_DEPTH 16

`endif

// file: hdl/symbol_codec_pkg.sv
package symbol_codec_pkg;

    // Transmit encoder states, one-hot
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_K = 4'h2,
        TX_DATA = 4'h4,
        TX_R = 4'h8
    } tx_state_type;

    // Receive decoder states, one-hot
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_K = 5'h02,
        RX_DATA = 5'h04,
        RX_T = 5'h08,
        RX_BAD = 5'h10
    } rx_state_type;

endpackage

// file: hdl/sym_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sym_fifo #(
    parameter int W = 6,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    input wire logic out_ready,
    output logic out_valid,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_ff [D]; // Storage, no reset needed for data
    logic [AW-1:0] wr_ptr_ff; // Next slot to fill
    logic [AW-1:0] rd_ptr_ff; // Head slot
    logic [AW:0] cnt_ff; // Words held
    logic [AW:0] nxt_cnt;
    logic push;
    logic pop;

    // Ready is registered so the source sees a clean level
    assign push = in_valid & in_ready;
    assign out_valid = (cnt_ff != '0);
    assign pop = out_valid & out_ready;
    assign out_data = mem_ff[rd_ptr_ff];
    assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage write
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data;
    end

    // Pointers, fill level and ready
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop);
            cnt_ff <= nxt_cnt;
            in_ready <= (nxt_cnt < (AW+1)'(D));
        end
    end
endmodule
`default_nettype wire

// file: hdl/fast_ethernet_symbol_codec.sv
// Contract
// (RULE1) Nibbles map to 16 of 32 groups
// (RULE2) Data groups follow the fixed 4B/5B table
// (RULE3) First preamble byte becomes J then K
// (RULE4) Later nibbles coded in arrival order
// (RULE5) Enable drop appends T then R
// (RULE6) IDLE fills the line between frames
// (RULE7) J after IDLE gives 0101, else error
// (RULE8) K after J gives 0101, else error
// (RULE9) T then R drops carrier, else error
// (RULE10) H or invalid group during frame errors
// (RULE11) Control groups inside data are errors
// (RULE12) Scrambler seed comes from PHY address
// (RULE13) Scrambled bits go NRZI then MLT-3
// (RULE14) MLT-3 steps on one, holds on zero
// (RULE15) Receive symbols sampled on recovered strobe
// (RULE16) One sampler fed from selected pair
// (RULE17) Odd nibble count adds one error nibble
// (RULE18) Strap bit disables error forwarding
// (RULE19) Bad start shows 1110 until two IDLEs
// (RULE20) Transmit error sends H for nibble
// (RULE21) MAC holds enable over whole frame
`timescale 1ns/1ps
`default_nettype none
`include "symbol_codec_map.svh"
module fast_ethernet_symbol_codec
    import symbol_codec_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // MII transmit side
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic [3:0] txd,
    output logic tx_ready,
    // Strap configuration
    input wire logic [4:0] phy_addr,
    input wire logic err_fwd_disable,
    // Line transmit level
    output logic [1:0] tx_mlt3,
    // Receive code groups from both cable pairs
    input wire logic rx_stb,
    input wire logic mdix_swap,
    input wire logic [4:0] rx_code_a,
    input wire logic [4:0] rx_code_b,
    // MII receive side
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic rx_er,
    output logic crs
);
    // Data nibble to code group
    function automatic logic [4:0] enc5(input logic [3:0] n);
        case (n)
            4'h0: enc5 = 5'h1E;
            4'h1: enc5 = 5'h09;
            4'h2: enc5 = 5'h14;
            4'h3: enc5 = 5'h15;
            4'h4: enc5 = 5'h0A;
            4'h5: enc5 = 5'h0B;
            4'h6: enc5 = 5'h0E;
            4'h7: enc5 = 5'h0F;
            4'h8: enc5 = 5'h12;
            4'h9: enc5 = 5'h13;
            4'hA: enc5 = 5'h16;
            4'hB: enc5 = 5'h17;
            4'hC: enc5 = 5'h1A;
            4'hD: enc5 = 5'h1B;
            4'hE: enc5 = 5'h1C;
            default: enc5 = 5'h1D;
        endcase
    endfunction

    // Code group to {valid, nibble}; control and invalid give valid low
    function automatic logic [4:0] dec5(input logic [4:0] c);
        dec5 = 5'h00;
        for (int i = 0; i < 16; i++)
            if (enc5(4'(i)) == c)
                dec5 = {1'b1, 4'(i)};
    endfunction

    // Transmit buffer and framing
    logic tx_en_d_ff; // Enable one cycle ago, finds the frame end
    logic q_in_valid;
    logic [5:0] q_in_data;
    logic q_valid; // Head word present
    logic [5:0] q_head; // {end, error, nibble}
    logic q_pop;

    // Frame nibbles enter the queue; one end marker follows enable drop
    assign q_in_valid = tx_en | tx_en_d_ff;
    assign q_in_data = tx_en ? {1'b0, tx_er, txd} : 6'h20;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            tx_en_d_ff <= 1'b0;
        else
            tx_en_d_ff <= tx_en;
    end

    // The MAC paces itself on tx_ready, since code groups leave slower
    sym_fifo #(.W(`TXQ_WIDTH), .D(`TXQ_DEPTH)) u_txq (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(q_in_valid),
        .in_data(q_in_data),
        .in_ready(tx_ready),
        .out_ready(q_pop),
        .out_valid(q_valid),
        .out_data(q_head)
    );

    // Encoder state
    tx_state_type tx_st_ff, nxt_tx_st;
    logic [2:0] bit_cnt_ff; // Bit slot within the code group
    logic [4:0] sh_ff; // Code group shifting out, first bit on top
    logic [4:0] nxt_code;
    logic odd_ff, nxt_odd; // Odd count of MAC nibbles so far
    logic sym_load;
    logic head_eof;
    logic head_er;
    logic [3:0] head_nib;

    assign sym_load = (bit_cnt_ff == `SYM_LAST_BIT);
    assign head_eof = q_head[5];
    assign head_er = q_head[4];
    assign head_nib = q_head[3:0];

    // Pick the next code group at each group boundary
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        nxt_code = `CG_IDLE; // [RULE6]
        nxt_odd = odd_ff;
        q_pop = 1'b0;
        if (sym_load)
        begin
            case (tx_st_ff)
                TX_IDLE:
                    if (q_valid && !head_eof)
                    begin
                        nxt_code = `CG_J; // [RULE3]
                        q_pop = 1'b1;
                        nxt_odd = 1'b1;
                        nxt_tx_st = TX_K;
                    end
                    else
                        q_pop = q_valid; // Stray marker dropped
                TX_K:
                begin
                    nxt_code = `CG_K; // [RULE3]
                    nxt_tx_st = TX_DATA;
                    if (q_valid && !head_eof)
                    begin
                        q_pop = 1'b1;
                        nxt_odd = 1'b0;
                    end
                end
                TX_DATA:
                    if (!q_valid)
                        nxt_code = `CG_H; // Underrun marks the frame bad
                    else if (head_eof && odd_ff && !err_fwd_disable)
                    begin
                        nxt_code = `CG_H; // [RULE17] [RULE18]
                        nxt_odd = 1'b0;
                    end
                    else if (head_eof)
                    begin
                        nxt_code = `CG_T; // [RULE5]
                        q_pop = 1'b1;
                        nxt_tx_st = TX_R;
                    end
                    else
                    begin
                        // [RULE1] [RULE2] [RULE4] [RULE20]
                        nxt_code = head_er ? `CG_H : enc5(head_nib);
                        q_pop = 1'b1;
                        nxt_odd = !odd_ff;
                    end
                TX_R:
                begin
                    nxt_code = `CG_R; // [RULE5]
                    nxt_tx_st = TX_IDLE;
                end
                default:
                    nxt_tx_st = TX_IDLE;
            endcase
        end
    end

    // Encoder registers and serialiser
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_st_ff <= TX_IDLE;
            bit_cnt_ff <= 3'h0;
            sh_ff <= `CG_IDLE;
            odd_ff <= 1'b0;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            bit_cnt_ff <= sym_load ? 3'h0 : bit_cnt_ff + 3'h1;
            sh_ff <= sym_load ? nxt_code : {sh_ff[3:0], 1'b0};
            odd_ff <= nxt_odd;
        end
    end

    // Scrambler, NRZI and MLT-3
    logic [10:0] lfsr_ff; // Key stream generator
    logic seeded_ff; // Seed taken after reset release
    logic scr_bit;
    logic nrzi_ff; // NRZI line bit
    logic [1:0] phase_ff; // MLT-3 position in 0,+1,0,-1 cycle
    logic [1:0] nxt_phase;
    logic [1:0] nxt_lvl;

    assign scr_bit = sh_ff[4] ^ lfsr_ff[10];
    assign nxt_phase = phase_ff + {1'b0, nrzi_ff}; // [RULE14]
    assign nxt_lvl = nxt_phase[0] ? {nxt_phase[1], 1'b1} : `LVL_ZERO;

    // Address is caught after reset, so reset itself loads only constants
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lfsr_ff <= 11'h7FF;
            seeded_ff <= 1'b0;
        end
        else if (!seeded_ff)
        begin
            lfsr_ff <= {phy_addr, `SEED_LOW}; // [RULE12]
            seeded_ff <= 1'b1;
        end
        else
            lfsr_ff <= {lfsr_ff[9:0], lfsr_ff[10] ^ lfsr_ff[8]};
    end

    // Line coding chain
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            nrzi_ff <= 1'b0;
            phase_ff <= 2'h0;
            tx_mlt3 <= `LVL_ZERO;
        end
        else
        begin
            nrzi_ff <= nrzi_ff ^ scr_bit; // [RULE13]
            phase_ff <= nxt_phase; // [RULE13]
            tx_mlt3 <= nxt_lvl;
        end
    end

    // Receive sampler and decoder
    rx_state_type rx_st_ff, nxt_rx_st;
    logic [4:0] rx_code_ff; // Sampled code group
    logic rx_stb_ff; // Sample strobe, one cycle
    logic prev_i_ff, nxt_prev_i; // Last group was IDLE
    logic [3:0] nxt_rxd;
    logic nxt_dv;
    logic nxt_er;
    logic nxt_crs;
    logic [4:0] rx_dec;
    logic is_i;
    logic is_j;
    logic is_k;
    logic is_t;
    logic is_r;

    assign rx_dec = dec5(rx_code_ff);
    assign is_i = (rx_code_ff == `CG_IDLE);
    assign is_j = (rx_code_ff == `CG_J);
    assign is_k = (rx_code_ff == `CG_K);
    assign is_t = (rx_code_ff == `CG_T);
    assign is_r = (rx_code_ff == `CG_R);

    // One sampler; the pair choice follows crossover resolution
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_code_ff <= `CG_IDLE;
            rx_stb_ff <= 1'b0;
        end
        else
        begin
            rx_stb_ff <= rx_stb; // [RULE15]
            if (rx_stb)
                rx_code_ff <= mdix_swap ? rx_code_b : rx_code_a; // [RULE16]
        end
    end

    // Decoder decisions, one per received group
    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_rxd = rxd;
        nxt_dv = rx_dv;
        nxt_er = rx_er;
        nxt_crs = crs;
        nxt_prev_i = prev_i_ff;
        if (rx_stb_ff)
        begin
            nxt_prev_i = is_i;
            case (rx_st_ff)
                RX_IDLE:
                    if (is_j)
                    begin
                        nxt_rx_st = RX_K;
                        nxt_rxd = `NIB_SSD; // [RULE7]
                        nxt_dv = 1'b1;
                        nxt_er = 1'b0;
                        nxt_crs = 1'b1;
                    end
                    else if (!is_i)
                    begin
                        nxt_rx_st = RX_BAD; // [RULE19] [RULE8] [RULE9]
                        nxt_rxd = `NIB_BAD_SSD;
                        nxt_dv = 1'b0;
                        nxt_er = 1'b1;
                        nxt_crs = 1'b1;
                    end
                RX_K:
                    if (is_k)
                    begin
                        nxt_rx_st = RX_DATA;
                        nxt_rxd = `NIB_SSD; // [RULE8]
                    end
                    else
                    begin
                        nxt_rx_st = RX_BAD; // [RULE8]
                        nxt_rxd = `NIB_BAD_SSD;
                        nxt_dv = 1'b0;
                        nxt_er = 1'b1;
                    end
                RX_DATA:
                    if (is_t)
                    begin
                        nxt_rx_st = RX_T; // Data stops, carrier waits on R
                        nxt_dv = 1'b0;
                        nxt_er = 1'b0;
                    end
                    else if (is_i && prev_i_ff)
                    begin
                        nxt_rx_st = RX_IDLE;
                        nxt_rxd = `NIB_ZERO; // Idle line shows a zero nibble
                        nxt_dv = 1'b0;
                        nxt_er = 1'b0;
                        nxt_crs = 1'b0;
                    end
                    else if (rx_dec[4])
                    begin
                        nxt_rxd = rx_dec[3:0];
                        nxt_er = 1'b0;
                    end
                    else
                        nxt_er = 1'b1; // [RULE10] [RULE11] [RULE7] [RULE9]
                RX_T:
                    if (is_r)
                    begin
                        nxt_rx_st = RX_IDLE; // [RULE9]
                        nxt_rxd = `NIB_ZERO; // Last data nibble not left on
                        nxt_crs = 1'b0;
                    end
                    else
                    begin
                        nxt_rx_st = RX_DATA; // [RULE9]
                        nxt_dv = 1'b1;
                        nxt_er = 1'b1;
                    end
                RX_BAD:
                    if (is_i && prev_i_ff)
                    begin
                        nxt_rx_st = RX_IDLE; // [RULE19]
                        nxt_rxd = `NIB_ZERO;
                        nxt_er = 1'b0;
                        nxt_crs = 1'b0;
                    end
                default:
                    nxt_rx_st = RX_IDLE;
            endcase
        end
    end

    // Decoder registers drive the MII outputs directly
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_st_ff <= RX_IDLE;
            prev_i_ff <= 1'b0;
            rxd <= `NIB_ZERO;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            crs <= 1'b0;
        end
        else
        begin
            rx_st_ff <= nxt_rx_st;
            prev_i_ff <= nxt_prev_i;
            rxd <= nxt_rxd;
            rx_dv <= nxt_dv;
            rx_er <= nxt_er;
            crs <= nxt_crs;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_enc_data: assert property ( // [RULE2]
        sym_load && tx_st_ff == TX_DATA && q_valid && !head_eof && !head_er
        |=> dec5(sh_ff) == {1'b1, $past(head_nib)})
        else $error("data nibble not coded");
    a_ssd_pair: assert property ( // [RULE3]
        sym_load && tx_st_ff == TX_IDLE && q_valid && !head_eof
        |=> sh_ff == `CG_J ##5 sh_ff == `CG_K)
        else $error("start pair not sent");
    a_esd_pair: assert property ( // [RULE5]
        sym_load && tx_st_ff == TX_DATA && q_valid && head_eof
        && !(odd_ff && !err_fwd_disable)
        |=> sh_ff == `CG_T ##5 sh_ff == `CG_R ##1 tx_st_ff == TX_IDLE)
        else $error("end pair not sent");
    a_idle_fill: assert property ( // [RULE6]
        sym_load && tx_st_ff == TX_IDLE && !q_valid |=> sh_ff == `CG_IDLE)
        else $error("idle not sent");
    a_odd_pad: assert property ( // [RULE17]
        sym_load && tx_st_ff == TX_DATA && q_valid && head_eof && odd_ff
        && !err_fwd_disable |=> sh_ff == `CG_H ##5 sh_ff == `CG_T)
        else $error("pad nibble missing");
    a_mlt3_hold: assert property ( // [RULE14]
        !nrzi_ff |=> tx_mlt3 == $past(tx_mlt3))
        else $error("mlt3 moved on zero");
    a_rx_ssd: assert property ( // [RULE7]
        rx_stb_ff && rx_st_ff == RX_IDLE && is_j
        |=> rxd == `NIB_SSD && crs && !rx_er)
        else $error("start group not decoded");
    a_rx_bad: assert property ( // [RULE19]
        rx_stb_ff && rx_st_ff == RX_IDLE && !is_i && !is_j
        |=> rx_er && rxd == `NIB_BAD_SSD && rx_st_ff == RX_BAD)
        else $error("bad start not flagged");
    a_rx_end: assert property ( // [RULE9]
        rx_stb_ff && rx_st_ff == RX_T && is_r |=> !crs && !rx_dv)
        else $error("carrier not dropped");
    a_rx_inval: assert property ( // [RULE10]
        rx_stb_ff && rx_st_ff == RX_DATA && !rx_dec[4] && !is_t && !is_i
        |=> rx_er)
        else $error("invalid group not flagged");

    c_tx_frame: cover property (tx_st_ff == TX_R && sym_load);
    c_tx_pad: cover property (sym_load && nxt_code == `CG_H && head_eof);
    c_rx_frame: cover property (rx_st_ff == RX_T ##1 rx_st_ff == RX_IDLE);
    c_rx_bad: cover property (rx_st_ff == RX_BAD);
endmodule
`default_nettype wire

// file: sim/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
    // Clock
    input wire logic clk_sys,
    // MAC transmit side
    input wire logic tx_ready,
    output logic tx_en,
    output logic tx_er,
    output logic [3:0] txd,
    // Remote line side, already aligned code groups
    input wire logic mdix_swap,
    output logic rx_stb,
    output logic [4:0] rx_code_a,
    output logic [4:0] rx_code_b
);
    // Quiet lines at time zero
    initial
    begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd = 4'h0;
        rx_stb = 1'b0;
        rx_code_a = 5'h00;
        rx_code_b = 5'h00;
    end

    // One group on the chosen pair, inverse on the other pair and
    // after the strobe, so a stale value can never pass for a group
    task automatic send_code(input logic [4:0] code);
        @(negedge clk_sys);
        rx_stb = 1'b1;
        rx_code_a = mdix_swap ? ~code : code;
        rx_code_b = mdix_swap ? code : ~code;
        @(negedge clk_sys);
        rx_stb = 1'b0;
        rx_code_a = ~rx_code_a;
        rx_code_b = ~rx_code_b;
    endtask

    // Whole frame under enable; a refused nibble is held and retried
    task automatic send_frame(input int n, input int err_at,
                              output logic stalled);
        int i;
        i = 0;
        stalled = 1'b0;
        while (i < n)
        begin
            @(negedge clk_sys);
            tx_en = 1'b1;
            txd = (i < 15) ? 4'h5 : ((i == 15) ? 4'hD : i[3:0]);
            tx_er = (i == err_at);
            if (tx_ready)
                i++;
            else
                stalled = 1'b1;
        end
        // Enable drops only where the end marker can be queued
        do
        begin
            @(negedge clk_sys);
        end
        while (!tx_ready);
        tx_en = 1'b0;
        tx_er = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: sim/fast_ethernet_symbol_codec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "symbol_codec_map.svh"
module fast_ethernet_symbol_codec_tb
    import symbol_codec_pkg::*;
;
    // Clock, reset and straps
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] phy_addr = 5'h01;
    logic err_fwd_disable = 1'b0;
    logic mdix_swap = 1'b0;
    // Partner to block and block outputs
    wire tx_en, tx_er, tx_ready, rx_stb, rx_dv, rx_er, crs;
    wire [3:0] txd, rxd;
    wire [4:0] rx_code_a, rx_code_b;
    wire [1:0] tx_mlt3;
    // Scoreboard
    int fail_count = 0;
    int n_tests = 0;
    // Line level watch state
    logic [1:0] prev_lvl = 2'h0;
    logic [1:0] last_nz = 2'h0;
    // Data code groups by nibble, and groups illegal inside data
    localparam logic [4:0] dcode [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
        5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
        5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] bad [13] = '{`CG_H, 5'h00, 5'h01, 5'h02,
        5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, `CG_J, `CG_K, `CG_R, `CG_IDLE};

    fast_ethernet_symbol_codec fast_ethernet_symbol_codec_inst (
        .clk_sys(clk_sys), .rst(rst), .tx_en(tx_en), .tx_er(tx_er),
        .txd(txd), .tx_ready(tx_ready), .phy_addr(phy_addr),
        .err_fwd_disable(err_fwd_disable), .tx_mlt3(tx_mlt3),
        .rx_stb(rx_stb), .mdix_swap(mdix_swap), .rx_code_a(rx_code_a),
        .rx_code_b(rx_code_b), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .crs(crs));

    link_partner_model link_partner_model_inst (
        .clk_sys(clk_sys), .tx_ready(tx_ready), .tx_en(tx_en),
        .tx_er(tx_er), .txd(txd), .mdix_swap(mdix_swap),
        .rx_stb(rx_stb), .rx_code_a(rx_code_a), .rx_code_b(rx_code_b));

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // Verdict; the only place the run ends
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Receive status {rxd, dv, er, crs} under a mask
    task automatic cmp_rx(input logic [6:0] got, input logic [6:0] exp,
                          input logic [6:0] mask);
        n_tests++;
        if ((got & mask) !== (exp & mask))
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got & mask, exp & mask);
        end
    endtask

    // Single flag
    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    // Reset for 10 cycles with a given address strap
    task automatic do_reset(input logic [4:0] addr);
        @(negedge clk_sys);
        rst = 1'b1;
        phy_addr = addr;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    // Send one group; outputs settle two edges after its strobe
    task automatic rx_group(input logic [4:0] code, input logic [6:0] exp,
                            input logic [6:0] mask);
        link_partner_model_inst.send_code(code);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp_rx({rxd, rx_dv, rx_er, crs}, exp, mask);
    endtask

    // Idle, start pair, framing
    task automatic rx_start();
        rx_group(`CG_IDLE, 7'h00, 7'h7F);
        rx_group(`CG_IDLE, 7'h00, 7'h7F);
        rx_group(`CG_J, {4'h5, 3'b101}, 7'h7F);
        rx_group(`CG_K, {4'h5, 3'b101}, 7'h7F);
    endtask

    // Line level watch: steps only through zero, signs alternate
    always @(negedge clk_sys)
    begin
        if (rst)
        begin
            prev_lvl <= 2'h0;
            last_nz <= 2'h0;
        end
        else if (tx_mlt3 !== prev_lvl)
        begin
            if (prev_lvl != 2'h0)
                cmp_bit(tx_mlt3 === 2'h0, 1'b1);
            else if (last_nz != 2'h0)
                cmp_bit(tx_mlt3 === {~last_nz[1], 1'b1}, 1'b1);
            else
                cmp_bit(tx_mlt3[0] === 1'b1, 1'b1);
            prev_lvl <= tx_mlt3;
            if (tx_mlt3 != 2'h0)
                last_nz <= tx_mlt3;
        end
    end

    // Idle line pattern depends on the address strap
    task automatic t_tx_seed();
        logic [127:0] sig_a;
        logic [127:0] sig_b;
        do_reset(5'h01);
        repeat (64) @(negedge clk_sys) sig_a = {sig_a[125:0], tx_mlt3};
        do_reset(5'h02);
        repeat (64) @(negedge clk_sys) sig_b = {sig_b[125:0], tx_mlt3};
        cmp_bit(sig_a !== sig_b, 1'b1);
        $display("test tx_seed done");
    endtask

    // Good frame with every data group, on either pair
    task automatic t_rx_frame(input logic swap);
        mdix_swap = swap;
        rx_start();
        for (int n = 0; n < 16; n++)
            rx_group(dcode[n], {n[3:0], 3'b101}, 7'h7F);
        rx_group(`CG_T, 7'h01, 7'h07);
        rx_group(`CG_R, 7'h00, 7'h07);
        mdix_swap = 1'b0;
        $display("test rx_frame pair %0d done", swap);
    endtask

    // Error and control groups inside data, then a lone end group
    task automatic t_rx_errors();
        rx_start();
        rx_group(5'h15, {4'h3, 3'b101}, 7'h7F);
        for (int k = 0; k < 13; k++)
        begin
            rx_group(bad[k], {4'h3, 3'b111}, 7'h7F);
            rx_group(5'h15, {4'h3, 3'b101}, 7'h7F);
        end
        rx_group(`CG_T, 7'h01, 7'h07);
        rx_group(5'h15, 7'h07, 7'h07);
        rx_group(`CG_T, 7'h01, 7'h07);
        rx_group(`CG_R, 7'h00, 7'h07);
        $display("test rx_errors done");
    endtask

    // Bad starts: stray group after idle, and J without K
    task automatic t_rx_bad_ssd();
        rx_group(`CG_IDLE, 7'h00, 7'h7F);
        rx_group(`CG_K, {4'hE, 3'b011}, 7'h7F);
        rx_group(5'h0A, {4'hE, 3'b011}, 7'h7F);
        link_partner_model_inst.send_code(`CG_IDLE);
        rx_group(`CG_IDLE, 7'h00, 7'h7F);
        rx_group(`CG_J, {4'h5, 3'b101}, 7'h7F);
        rx_group(5'h0A, {4'hE, 3'b011}, 7'h7F);
        link_partner_model_inst.send_code(`CG_IDLE);
        rx_group(`CG_IDLE, 7'h00, 7'h7F);
        $display("test rx_bad_ssd done");
    endtask

    // Long frames overrun the queue; the line keeps legal levels
    task automatic t_tx_frames();
        logic stalled;
        err_fwd_disable = 1'b0;
        link_partner_model_inst.send_frame(41, 20, stalled);
        cmp_bit(stalled, 1'b1);
        // Strap is read when the end marker reaches the head, so drain first
        repeat (200) @(negedge clk_sys);
        cmp_bit(tx_ready, 1'b1);
        err_fwd_disable = 1'b1;
        link_partner_model_inst.send_frame(40, -1, stalled);
        cmp_bit(stalled, 1'b1);
        // Let the queue drain so every group reaches the line
        repeat (400) @(negedge clk_sys);
        cmp_bit(tx_ready, 1'b1);
        $display("test tx_frames done");
    endtask

    // Main sequence
    initial
    begin
        t_tx_seed();
        t_rx_frame(1'b0);
        t_rx_frame(1'b1);
        t_rx_errors();
        t_rx_bad_ssd();
        t_tx_frames();
        conclude();
    end

    // Watchdog at 20000 cycles, well beyond the 1400 or so cycles the tests need
    initial
    begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
